//--- src/tdc_top.v
// Touchless dispenser controller: power states, scan, dispensing.
// Assumes synchronous sensor and switch inputs and an APB master.
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "tdc_consts.vh"
module tdc_top #(
   parameter [31:0] WAKE_CYC = `TDC_CLK_HZ / 1000 * `TDC_WAKE_MS,
   parameter [31:0] DISP_CYC = `TDC_CLK_HZ / 1000 * `TDC_MAX_DISP_MS,
   parameter [31:0] DN_CYC   = `TDC_CLK_HZ / 1000000 * `TDC_DOSE_NORMAL_UL,
   parameter [31:0] DL_CYC   = `TDC_CLK_HZ / 1000000 * `TDC_DOSE_LIGHT_UL,
   parameter [31:0] LB_CYC   = `TDC_CLK_HZ / 1000 * `TDC_LOWBAT_MS / 2
) (
   input  wire        CORE_CLK,
   input  wire        SYS_RST,
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [7:0]  PADDR,
   input  wire [31:0] PWDATA,
   output reg  [31:0] PRDATA,
   output wire        PREADY,
   output wire        PSLVERR,
   output wire        IRQ,
   output wire        SCAN_START,
   input  wire        SCAN_DONE,
   input  wire        HAND_IN,
   input  wire        LIGHT_SEL,
   input  wire        BATT_LOW,
   output wire        BATT_SAMPLE,
   output wire        PUMP_PWM,
   output reg         LED_ON,
   output reg         BUZZER_OUT
);
   localparam [2:0] ST_INIT  = 3'd0;
   localparam [2:0] ST_STOP  = 3'd1;
   localparam [2:0] ST_SNOOZE= 3'd2;
   localparam [2:0] ST_EVAL  = 3'd3;
   localparam [2:0] ST_DISP  = 3'd4;
   localparam [2:0] ST_ALARM = 3'd5;
   localparam [31:0] TONE_HALF = `TDC_CLK_HZ / (2 * `TDC_BUZ_HZ);

   reg  [2:0]  state_r;
   reg  [2:0]  state_nxt;
   reg  [31:0] wake_r;
   reg  [31:0] disp_r;
   reg  [31:0] tone_r;
   reg  [31:0] lb_r;
   reg         tone_lvl_r;
   reg         gate_r;
   reg         init_r;
   reg         light_r;
   reg  [`TDC_EV_W-1:0] ist_r;
   reg  [`TDC_EV_W-1:0] imask_r;
   wire [`TDC_EV_W-1:0] ev;
   wire        wake_ev;
   wire        dose_end;
   wire        acc;
   wire        wr;
   wire        rd_ist;
   wire        in_stop;
   wire        in_snooze;
   wire        in_eval;
   wire        in_disp;
   wire        in_alarm;
   genvar      gi;

   // APB access phase, single wait-free answer
   assign acc     = PSEL & PENABLE;
   assign wr      = acc & PWRITE;
   assign rd_ist  = acc & !PWRITE & (PADDR == `TDC_REG_IRQ_STAT);
   assign PREADY  = 1'b1;
   assign PSLVERR = 1'b0;

   // 32-bit periodic interval timer, runs after init
   assign wake_ev = init_r && (wake_r == WAKE_CYC - 32'd1);
   always @(posedge CORE_CLK) begin
      if (SYS_RST || !init_r)
         wake_r <= 32'h00000000;
      else if (wake_ev)
         wake_r <= 32'h00000000;
      else
         wake_r <= wake_r + 32'd1;
   end

   // Dose time depends on the selector latched at hand-in
   // Pump runs for exactly the dose length in cycles
   assign dose_end = light_r ? (disp_r >= DL_CYC) :
                               (disp_r >= DN_CYC);

   // State register
   always @(posedge CORE_CLK) begin
      if (SYS_RST)
         state_r <= ST_INIT;
      else
         state_r <= state_nxt;
   end

   // Next-state logic
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_INIT:   if (init_r) state_nxt = ST_STOP;
         ST_STOP:   if (wake_ev) state_nxt = ST_SNOOZE;
         ST_SNOOZE: if (SCAN_DONE) state_nxt = ST_EVAL;
         ST_EVAL: begin
            if (!HAND_IN)
               state_nxt = ST_STOP;
            else if (BATT_LOW)
               state_nxt = ST_ALARM;
            else
               state_nxt = ST_DISP;
         end
         ST_DISP, ST_ALARM: begin
            if (!HAND_IN || disp_r >= DISP_CYC - 32'd1)
               state_nxt = ST_STOP;
         end
         default:   state_nxt = ST_INIT;
      endcase
   end

   // Scan start routed from the timer event while waking
   assign SCAN_START  = in_stop && wake_ev;
   assign BATT_SAMPLE = (state_r == ST_EVAL);

   // Hand-in duration and selector capture
   always @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         disp_r  <= 32'h00000000;
         light_r <= 1'b0;
      end else if (state_r == ST_EVAL) begin
         disp_r  <= 32'h00000000;
         light_r <= LIGHT_SEL;
      end else if (state_r == ST_DISP || state_r == ST_ALARM) begin
         disp_r  <= disp_r + 32'd1;
      end
   end

   // Pump runs until the dose is out
   tdc_pwm u_pwm (
      .clk   (CORE_CLK),
      .rst   (SYS_RST),
      .run   ((state_r == ST_DISP) && !dose_end),
      .light (light_r),
      .pwm   (PUMP_PWM)
   );

   // State decode shared by outputs and events
   assign in_stop   = (state_r == ST_STOP);
   assign in_snooze = (state_r == ST_SNOOZE);
   assign in_eval   = (state_r == ST_EVAL);
   assign in_disp   = (state_r == ST_DISP);
   assign in_alarm  = (state_r == ST_ALARM);

   // Tone restarts high at each indication so it sounds at once
   always @(posedge CORE_CLK) begin
      if (SYS_RST || !(in_disp || in_alarm)) begin
         tone_r     <= 32'h00000000;
         tone_lvl_r <= 1'b1;
      end else if (tone_r == TONE_HALF - 32'd1) begin
         tone_r     <= 32'h00000000;
         tone_lvl_r <= !tone_lvl_r;
      end else begin
         tone_r     <= tone_r + 32'd1;
      end
   end

   // Low-battery gate, starts sounding on alarm entry
   always @(posedge CORE_CLK) begin
      if (SYS_RST || !in_alarm) begin
         lb_r   <= 32'h00000000;
         gate_r <= 1'b1;
      end else if (lb_r == LB_CYC - 32'd1) begin
         lb_r   <= 32'h00000000;
         gate_r <= !gate_r;
      end else begin
         lb_r   <= lb_r + 32'd1;
      end
   end

   // Indicator outputs, idle in stop and snooze
   always @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         LED_ON     <= 1'b0;
         BUZZER_OUT <= 1'b0;
      end else begin
         LED_ON     <= in_disp;
         BUZZER_OUT <= tone_lvl_r & (in_disp | (in_alarm & gate_r));
      end
   end

   // Event strobes, one cycle each
   assign ev[`TDC_EV_WAKE]    = wake_ev;
   assign ev[`TDC_EV_SCAN]    = in_snooze & SCAN_DONE;
   assign ev[`TDC_EV_DISP]    = (state_nxt == ST_DISP) & in_eval;
   assign ev[`TDC_EV_LOWBAT]  = (state_nxt == ST_ALARM) & in_eval;
   assign ev[`TDC_EV_TIMEOUT] = (in_disp | in_alarm) & HAND_IN &
                                (disp_r >= DISP_CYC - 32'd1);
   assign IRQ = |(ist_r & imask_r);

   // Sticky status per event, set wins over read clear
   generate
      for (gi = 0; gi < `TDC_EV_W; gi = gi + 1) begin : g_ist
         always @(posedge CORE_CLK) begin
            if (SYS_RST)
               ist_r[gi] <= 1'b0;
            else if (ev[gi])
               ist_r[gi] <= 1'b1; // Event in the read cycle stays
            else if (rd_ist)
               ist_r[gi] <= 1'b0;
         end
      end
   endgenerate

   // Writable registers
   always @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         init_r  <= 1'b0;
         imask_r <= {`TDC_EV_W{1'b0}};
      end else begin
         if (wr && PADDR == `TDC_REG_CTRL && PWDATA[`TDC_CTRL_INIT_DONE])
            init_r <= 1'b1;
         if (wr && PADDR == `TDC_REG_IRQ_MASK)
            imask_r <= PWDATA[`TDC_EV_W-1:0];
      end
   end

   // Read data, registered in the setup phase
   always @(posedge CORE_CLK) begin
      if (SYS_RST)
         PRDATA <= 32'h00000000;
      else if (PSEL && !PENABLE && !PWRITE) begin
         case (PADDR)
            `TDC_REG_CTRL:     PRDATA <= {31'h0, init_r};
            `TDC_REG_STATUS:   PRDATA <= {29'h0, state_r};
            `TDC_REG_IRQ_STAT: PRDATA <= {27'h0, ist_r};
            `TDC_REG_IRQ_MASK: PRDATA <= {27'h0, imask_r};
            `TDC_REG_OPTION:   PRDATA <= {`TDC_OPT_DEBUG, `TDC_OPT_FREQ,
                                          `TDC_OPT_LVD, `TDC_OPT_WDT};
            `TDC_REG_TIMER:    PRDATA <= wake_r;
            default:           PRDATA <= 32'h00000000;
         endcase
      end
   end
endmodule // tdc_top
`default_nettype wire

//--- src/tdc_consts.vh
// Constants for the touchless dispenser controller.
// Assumes a 100 MHz core clock and an APB master on the register port.
//
// Functional notes
// - Pump PWM full duty normal, 3/4 light
// - Light mode dispenses half millilitre, LED, buzzer
// - Normal mode dispenses 0.8 ml, LED, buzzer
// - 32-bit interval timer wakes every 100 ms
// - After init, enter stop state
// - Stop leaves to snooze only on timer event
// - Timer event starts scan within snooze
// - Scan done enters normal, evaluates hand
// - Low battery: buzzer alarm, LED and pump off
// - Back to stop on hand-out or timeout
// - Start-up word keeps watchdog stopped
// - Start-up words: detector reset mode, debug off
// - Dispense buzzer tone about 2 kHz square
// - Low battery buzzer gated at 100 ms period
// - Battery sampled on every hand detection
`ifndef TDC_CONSTS_VH
`define TDC_CONSTS_VH

`define TDC_CLK_HZ        100000000
// Register byte offsets
`define TDC_REG_CTRL      8'h00
`define TDC_REG_STATUS    8'h04
`define TDC_REG_IRQ_STAT  8'h08
`define TDC_REG_IRQ_MASK  8'h0C
`define TDC_REG_OPTION    8'h10
`define TDC_REG_TIMER     8'h14
// Control fields
`define TDC_CTRL_INIT_DONE 0
// Interrupt event bit positions
`define TDC_EV_WAKE       0
`define TDC_EV_SCAN       1
`define TDC_EV_DISP       2
`define TDC_EV_LOWBAT     3
`define TDC_EV_TIMEOUT    4
`define TDC_EV_W          5
// Start-up option words
`define TDC_OPT_WDT       8'hEF
`define TDC_OPT_LVD       8'hFC
`define TDC_OPT_FREQ      8'hAD
`define TDC_OPT_DEBUG     8'h04
// Times in their own units
`define TDC_WAKE_MS       100
`define TDC_MAX_DISP_MS   2000
`define TDC_BUZ_HZ        2048
`define TDC_LOWBAT_MS     100
// Dose per motion in microlitres
`define TDC_DOSE_NORMAL_UL 800
`define TDC_DOSE_LIGHT_UL  500
// PWM frame and light-mode compare value
`define TDC_PWM_PERIOD    8'h64
`define TDC_PWM_LIGHT     8'h4B

`endif

//--- src/tdc_pwm.v
// Pump PWM generator with a fixed frame.
// Assumes a synchronous active-high reset on the core clock.
`timescale 1ns/1ps
`default_nettype none
`include "tdc_consts.vh"
module tdc_pwm (
   input  wire       clk,
   input  wire       rst,
   input  wire       run,
   input  wire       light,
   output reg        pwm
);
   reg  [7:0] cnt_r;
   wire [7:0] cmp;

   // Compare level per dose mode
   assign cmp = light ? `TDC_PWM_LIGHT : `TDC_PWM_PERIOD;

   // Frame counter and output
   always @(posedge clk) begin
      if (rst || !run) begin
         cnt_r <= 8'h00;
         pwm   <= 1'b0;
      end else begin
         cnt_r <= (cnt_r == `TDC_PWM_PERIOD - 8'd1) ? 8'h00 :
                  cnt_r + 8'd1;
         pwm   <= (cnt_r < cmp);
      end
   end
endmodule // tdc_pwm
`default_nettype wire

//--- tb/tdc_properties.sv
// Pin-level assertions for the dispenser controller.
// Assumes binding into tdc_top; counts come from its parameters.
`timescale 1ns/1ps
`default_nettype none
module tdc_properties #(
   parameter [31:0] WAKE_CYC = 32'hC8,
   parameter [31:0] DISP_CYC = 32'h7D0
) (
   input wire CORE_CLK,
   input wire SYS_RST,
   input wire SCAN_START,
   input wire SCAN_DONE,
   input wire HAND_IN,
   input wire BATT_LOW,
   input wire BATT_SAMPLE,
   input wire PUMP_PWM,
   input wire LED_ON,
   input wire BUZZER_OUT
);
   logic [31:0] gap_r;
   logic [31:0] run_r;
   logic        seen_r;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);
   // Time since last scan start, length of current LED run
   always @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         gap_r <= 32'h0;
         run_r <= 32'h0;
         seen_r <= 1'b0;
      end else begin
         gap_r <= SCAN_START ? 32'h1 : gap_r + 32'h1;
         run_r <= LED_ON ? run_r + 32'h1 : 32'h0;
         seen_r <= seen_r | SCAN_START;
      end
   end
   sequence s_ok;
      BATT_SAMPLE && HAND_IN && !BATT_LOW;
   endsequence
   sequence s_low;
      BATT_SAMPLE && HAND_IN && BATT_LOW;
   endsequence
   a_scan_quiet: assert property (SCAN_START |=> !LED_ON && !PUMP_PWM && !BUZZER_OUT) else $error("outputs active at scan");
   a_scan_pulse: assert property (SCAN_START |=> !SCAN_START [*8]) else $error("scan start repeats");
   a_eval_cause: assert property (BATT_SAMPLE |-> $past(SCAN_DONE)) else $error("eval without scan done");
   a_eval_once: assert property (BATT_SAMPLE |=> !BATT_SAMPLE) else $error("battery sample too long");
   a_disp_led: assert property (s_ok |-> ##[1:2] LED_ON) else $error("no dispense on hand");
   a_low_dark: assert property (s_low |=> (!LED_ON && !PUMP_PWM) [*8]) else $error("dispense on low battery");
   a_hand_out: assert property (LED_ON && !HAND_IN |-> ##[1:2] !LED_ON) else $error("LED stays after hand out");
   a_disp_limit: assert property (run_r <= DISP_CYC + 32'h1) else $error("dispense too long");
   a_wake_grid: assert property (SCAN_START && seen_r |-> gap_r % WAKE_CYC == 32'h0) else $error("wake off period");
endmodule // tdc_properties
bind tdc_top tdc_properties #(.WAKE_CYC(WAKE_CYC), .DISP_CYC(DISP_CYC)) i_tdc_properties (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .SCAN_START(SCAN_START), .SCAN_DONE(SCAN_DONE), .HAND_IN(HAND_IN), .BATT_LOW(BATT_LOW), .BATT_SAMPLE(BATT_SAMPLE), .PUMP_PWM(PUMP_PWM), .LED_ON(LED_ON), .BUZZER_OUT(BUZZER_OUT));
`default_nettype wire

//--- tb/tdc_sense.sv
// Capacitive sense model: ends each scan after a set delay.
// Assumes the bench picks the delay, at least one cycle.
`timescale 1ns/1ps
`default_nettype none
module tdc_sense (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       start,
   input  wire logic [3:0] lat,
   output var  logic       done
);
   logic [3:0] cnt_r;
   // Count down the scan, pulse completion once
   always @(posedge clk) begin
      done <= !rst && cnt_r == 4'h1;
      if (rst)
         cnt_r <= 4'h0;
      else if (start)
         cnt_r <= lat;
      else if (cnt_r != 4'h0)
         cnt_r <= cnt_r - 4'h1;
   end
endmodule // tdc_sense
`default_nettype wire

//--- tb/tdc_top_tb.sv
// Testbench for the dispenser controller over APB and pins.
// Assumes shortened counts and the sense model on the scan pins.
`timescale 1ns/1ps
`default_nettype none
module tdc_top_tb;
   localparam int DC = 2000;
   logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwd = 32'h0, prd, lf = 32'h1F;
   logic        pready, pslverr, irq, ss, sd, hand = 0, light = 0;
   logic        low = 0, bs, pump, led, buz;
   logic [3:0]  lat = 4'h1;
   logic [31:0] eq[$], mq[$];
   int          error_cnt = 0, n_tests = 0, cyc = 0;
   tdc_top #(.WAKE_CYC(200), .DISP_CYC(DC), .DN_CYC(80), .DL_CYC(200),
      .LB_CYC(20)) i_tdc_top (.CORE_CLK(clk), .SYS_RST(rst), .PSEL(psel),
      .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwd),
      .PRDATA(prd), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq),
      .SCAN_START(ss), .SCAN_DONE(sd), .HAND_IN(hand), .LIGHT_SEL(light),
      .BATT_LOW(low), .BATT_SAMPLE(bs), .PUMP_PWM(pump), .LED_ON(led),
      .BUZZER_OUT(buz));
   tdc_sense i_tdc_sense (.clk(clk), .rst(rst), .start(ss), .lat(lat),
      .done(sd));
   always #5 clk = ~clk;
   function automatic logic [31:0] nx(logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         error_cnt++;
         $display("MISMATCH %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // One APB transfer; a read notes its expected value
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d, m);
      @(posedge clk);
      if (!w) begin
         eq.push_back(d);
         mq.push_back(m);
      end
      psel <= 1;
      pen <= 0;
      pwr <= w;
      paddr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 0;
      pen <= 0;
   endtask
   // Hand held for a window while outputs are counted
   task automatic dose(logic li, lo, int win, ep, el);
      int np = 0, nl = 0, nb = 0, run = 0, mr = 0;
      @(posedge clk);
      lf = nx(lf);
      lat <= lf[3:0] | 4'h1;
      light <= li;
      low <= lo;
      hand <= 1;
      while (bs !== 1'b1) @(negedge clk);
      repeat (win) begin
         @(negedge clk);
         np += pump;
         nl += led;
         nb += buz;
         run = led ? run + 1 : 0;
         mr = run > mr ? run : mr;
      end
      @(posedge clk);
      hand <= 0;
      if (ep >= 0) chk("pump", np, ep);
      chk("led", nl > 0, el);
      if (ep >= 0) chk("buzzer", nb, lo ? 80 : win - 1);
      else chk("buzzer", nb > 0, 1);
      if (ep < 0) chk("limit", mr >= DC - 2 && mr <= DC + 1, 1);
      repeat (8) @(posedge clk);
      $display("test done: dose li=%0d lo=%0d", li, lo);
   endtask
   always @(posedge clk)
      if (psel && pen && pready && !pwr) chk("prdata", prd & mq.pop_front(), eq.pop_front());
   // Every completed transfer answers without error
   always @(posedge clk)
      if (psel && pen && pready) chk("pslverr", pslverr, 0);
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         conclude;
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      rst <= 0;
      apb(0, 8'h10, 32'h04ADFCEF, 32'hFFFFFFFF);
      apb(0, 8'h04, 32'h0, 32'h7);
      lf = nx(lf);
      apb(1, 8'h18, lf, 32'h0);
      apb(0, 8'h18, 32'h0, 32'hFFFFFFFF);
      apb(1, 8'h0C, 32'h1, 32'h0);
      apb(1, 8'h00, 32'h1, 32'h0);
      apb(0, 8'h04, 32'h1, 32'h7);
      while (irq !== 1'b1) @(negedge clk);
      apb(0, 8'h08, 32'h1, 32'h1);
      apb(0, 8'h08, 32'h0, 32'h1);
      @(negedge clk);
      chk("irq", irq, 0);
      apb(1, 8'h0C, 32'h0, 32'h0);
      $display("test done: registers and wake");
      dose(0, 0, 150, 80, 1);
      dose(1, 0, 250, 150, 1);
      dose(0, 1, 150, 0, 0);
      dose(0, 0, 2300, -1, 1);
      conclude;
   end
endmodule // tdc_top_tb
`default_nettype wire
